// ---- logic/load_port_pkg.sv ----
// constants and types for the sequential display load port
package load_port_pkg;
  localparam int unsigned BUS_W        = 8;     // input bus width
  localparam int unsigned DIGITS       = 8;     // digit memory depth
  localparam int unsigned PTR_W        = 3;     // digit pointer width
  // configuration word bit positions
  localparam int unsigned CFG_FOLLOW_BIT  = 7;  // data follows
  localparam int unsigned CFG_CHARSET_BIT = 6;  // 1 = hex, 0 = alternate set
  localparam int unsigned CFG_DECODE_BIT  = 5;  // 1 = decode, 0 = raw
  localparam int unsigned CFG_ACTIVE_BIT  = 4;  // 1 = active, 0 = shutdown
  // raw byte bit positions
  localparam int unsigned RAW_DP_BIT   = 7;
  localparam int unsigned RAW_A_BIT    = 6;
  localparam int unsigned RAW_B_BIT    = 5;
  localparam int unsigned RAW_C_BIT    = 4;
  localparam int unsigned RAW_E_BIT    = 3;
  localparam int unsigned RAW_G_BIT    = 2;
  localparam int unsigned RAW_F_BIT    = 1;
  localparam int unsigned RAW_D_BIT    = 0;
  // reset values
  localparam logic [7:0] MEM_RST       = 8'h00;
  localparam logic [2:0] PTR_RST       = 3'h0;
  localparam logic       SHUT_RST      = 1'b1;  // dark until configured
  localparam logic       DECODE_RST    = 1'b0;
  localparam logic       CHARSET_RST   = 1'b1;
  typedef enum logic [1:0] {LOAD_IDLE, LOAD_FILL, LOAD_FULL} load_state_t;
endpackage : load_port_pkg

// ---- logic/strobe_if.sv ----
// carrier for a qualified write event between strobe front end and core
`timescale 1ns/1ps
interface strobe_if;
  logic       wr_evt;   // one-cycle pulse on strobe fall
  logic       mode;     // mode line sampled with the event
  logic [7:0] data;     // bus sampled with the event
  modport src (output wr_evt, output mode, output data);
  modport dst (input wr_evt, input mode, input data);
endinterface : strobe_if

// ---- logic/strobe_front.sv ----
// edge detector that turns the write strobe into one-cycle events
`timescale 1ns/1ps
module strobe_front
  import load_port_pkg::*;
(
  input  wire logic             ref_clk,     // system clock
  input  wire logic             reset,       // sync reset, high
  input  wire logic             wr_n,        // write strobe, low active
  input  wire logic             mode_in,     // mode select line
  input  wire logic [BUS_W-1:0] bus_in,      // input_bus_bits
  strobe_if.src                 evt          // qualified event out
);
  logic wr_n_r;
  logic fall;

  // one event per low pulse; a long low pulse still counts once
  assign fall = wr_n_r & ~wr_n;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_n_r <= 1'b1;
    end else begin
      wr_n_r <= wr_n;
    end
  end

  // capture bus and mode with the edge, hold otherwise
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      evt.wr_evt <= 1'b0;
      evt.mode   <= 1'b0;
      evt.data   <= 8'h00;
    end else begin
      evt.wr_evt <= fall;
      if (fall) begin
        evt.mode <= mode_in;
        evt.data <= bus_in;
      end
    end
  end

  strobe_single_a: assert property (@(posedge ref_clk) disable iff (reset)
    evt.wr_evt |=> !evt.wr_evt)
    else $error("write event lasted more than one cycle");
endmodule // strobe_front

// ---- logic/seq_display_load.sv ----
// sequential-load display port: config word, digit memory, raw segment view
//
// Notes on behaviour
// - one 8-bit bus carries config and data; each transfer is one strobe pulse
// - mode high at strobe: bus is latched as configuration word
// - mode low at strobe: bus is a display byte for digit memory
// - each display byte goes to next location; pointer advances by itself
// - after eight bytes, display bytes are ignored until a new config word with data-follows
// - raw mode: each stored bit drives one LED, eight per digit
// - config word holds decode, charset, shutdown and data-follows bits
// - raw bits seven to zero map to dp, a, b, c, e, g, f, d
// - one lights a segment, except decimal point which lights on zero
// - shutdown blanks outputs but memory writes still land
`timescale 1ns/1ps
module seq_display_load
  import load_port_pkg::*;
#(
  parameter int unsigned DEPTH = DIGITS   // digit memory locations
)(
  input  wire logic             ref_clk,     // 200 MHz clock
  input  wire logic             reset,       // sync reset, high
  input  wire logic             wr_n,        // write strobe, low active
  input  wire logic             mode_sel,    // high = config word
  input  wire logic [BUS_W-1:0] input_bus_bits, // shared data bus
  input  wire logic [PTR_W-1:0] view_digit,  // digit to present on seg outputs
  output logic      [7:0]       seg_on,      // lit segments {dp,g,f,e,d,c,b,a}
  output logic                  shutdown,    // display sections off
  output logic                  decode_en,   // decoder in use
  output logic                  charset_select, // 1 = hex set
  output logic                  loading,     // bytes still accepted
  output logic      [PTR_W-1:0] load_ptr     // next location to fill
);
  // front-end event carrier, sequencer state, storage and config latches
  strobe_if evt ();
  load_state_t state_r, state_nxt;
  logic [7:0]       mem_r [DEPTH];
  logic [PTR_W-1:0] ptr_r, ptr_nxt;
  logic             shut_r, dec_r, cs_r;
  logic             cfg_wr, data_wr, store, last_slot, follow;
  logic [7:0]       raw;

  strobe_front u_front (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_n    (wr_n),
    .mode_in (mode_sel),
    .bus_in  (input_bus_bits),
    .evt     (evt)
  );

  // event decode
  assign cfg_wr    = evt.wr_evt & evt.mode;
  assign data_wr   = evt.wr_evt & ~evt.mode;
  assign follow    = evt.data[CFG_FOLLOW_BIT];
  // stores continue in shutdown, only the display is gated
  assign store     = data_wr & (state_r == LOAD_FILL);
  assign last_slot = (ptr_r == PTR_W'(DEPTH - 1));

  // load sequencer: idle until a config with data-follows
  // a config word without data-follows stops loading at once
  always_comb begin
    state_nxt = state_r;
    ptr_nxt   = ptr_r;
    case (state_r)
      LOAD_IDLE, LOAD_FULL: begin
        if (cfg_wr && follow) begin
          state_nxt = LOAD_FILL;
          ptr_nxt   = PTR_RST;
        end
      end
      LOAD_FILL: begin
        if (cfg_wr && follow) begin
          ptr_nxt = PTR_RST;
        end else if (cfg_wr) begin
          state_nxt = LOAD_IDLE;
        end else if (store) begin
          ptr_nxt = ptr_r + PTR_W'(1);
          if (last_slot) begin
            state_nxt = LOAD_FULL;
            ptr_nxt   = PTR_RST;                         // park at zero for any depth
          end
        end
      end
      default: begin
        state_nxt = LOAD_IDLE;
        ptr_nxt   = PTR_RST;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= LOAD_IDLE;
      ptr_r   <= PTR_RST;
    end else begin
      state_r <= state_nxt;
      ptr_r   <= ptr_nxt;
    end
  end

  // configuration word latch
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shut_r <= SHUT_RST;
      dec_r  <= DECODE_RST;
      cs_r   <= CHARSET_RST;
    end else if (cfg_wr) begin
      shut_r <= ~evt.data[CFG_ACTIVE_BIT];
      dec_r  <= evt.data[CFG_DECODE_BIT];
      cs_r   <= evt.data[CFG_CHARSET_BIT];
    end
  end

  // digit memory, no reset on the array so it maps to plain storage
  // writes land in shutdown too; only the view below is blanked
  always_ff @(posedge ref_clk) begin
    if (store) begin
      mem_r[ptr_r] <= evt.data;
    end
  end

  // raw segment view; decoded character sets are drawn elsewhere
  // view_digit is a free read port, so any digit can be shown any time outside shutdown
  assign raw = mem_r[view_digit];

  // segment register: one stage so the outputs never show decode glitches,
  // at the cost of one cycle between view_digit and seg_on
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      seg_on <= MEM_RST;
    end else if (shut_r) begin
      seg_on <= 8'h00;
    end else begin
      seg_on <= {~raw[RAW_DP_BIT],
                 raw[RAW_G_BIT], raw[RAW_F_BIT], raw[RAW_E_BIT],
                 raw[RAW_D_BIT], raw[RAW_C_BIT], raw[RAW_B_BIT], raw[RAW_A_BIT]};
    end
  end

  // status outputs straight from the registers
  assign shutdown       = shut_r;
  assign decode_en      = dec_r;
  assign charset_select = cs_r;
  assign loading        = (state_r == LOAD_FILL);
  assign load_ptr       = ptr_r;

  // checks; each property but ptr_range_a looks one edge past the event that it guards,
  // since every state, pointer and config change is registered on that edge

  // load sequencing
  ptr_advance_a: assert property (@(posedge ref_clk) disable iff (reset)
    store && !last_slot |=> ptr_r == $past(ptr_r) + PTR_W'(1))
    else $error("pointer did not advance after a stored byte");
  full_ignore_a: assert property (@(posedge ref_clk) disable iff (reset)
    state_r == LOAD_FULL && !cfg_wr |=> state_r == LOAD_FULL && ptr_r == PTR_RST)
    else $error("full state left without a config word");
  eighth_full_a: assert property (@(posedge ref_clk) disable iff (reset)
    store && last_slot && !cfg_wr |=> state_r == LOAD_FULL)
    else $error("eighth byte did not close loading");
  full_entry_a: assert property (@(posedge ref_clk) disable iff (reset)
    store && last_slot |=> !loading && ptr_r == PTR_RST)
    else $error("pointer not parked after the last byte");
  cfg_rewind_a: assert property (@(posedge ref_clk) disable iff (reset)
    cfg_wr && follow |=> ptr_r == PTR_RST && loading)
    else $error("data-follows config did not rewind pointer");
  store_slot_a: assert property (@(posedge ref_clk) disable iff (reset)
    store |=> mem_r[$past(ptr_r)] == $past(evt.data))
    else $error("display byte not stored at the pointer");
  ptr_range_a: assert property (@(posedge ref_clk) disable iff (reset)
    ptr_r <= PTR_W'(DEPTH - 1))
    else $error("pointer beyond the last digit location");
  fill_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    loading && !evt.wr_evt |=> loading && $stable(ptr_r))
    else $error("pointer moved without a write");
  refuse_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
    data_wr && !loading |=> !loading && $stable(ptr_r))
    else $error("display byte taken while not loading");

  // configuration
  cfg_latch_a: assert property (@(posedge ref_clk) disable iff (reset)
    cfg_wr |=> shutdown == !$past(evt.data[CFG_ACTIVE_BIT])
           && decode_en == $past(evt.data[CFG_DECODE_BIT]))
    else $error("config bits not latched");
  cs_latch_a: assert property (@(posedge ref_clk) disable iff (reset)
    cfg_wr |=> charset_select == $past(evt.data[CFG_CHARSET_BIT]))
    else $error("character set bit not latched");
  cfg_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
    !cfg_wr |=> $stable(shutdown) && $stable(decode_en) && $stable(charset_select))
    else $error("configuration changed without a config word");
  data_no_cfg_a: assert property (@(posedge ref_clk) disable iff (reset)
    data_wr |=> $stable(shutdown) && $stable(decode_en))
    else $error("display byte altered configuration");
  cfg_stop_a: assert property (@(posedge ref_clk) disable iff (reset)
    cfg_wr && !follow |=> !loading)
    else $error("config without data-follows left loading on");

  // segment view
  shut_dark_a: assert property (@(posedge ref_clk) disable iff (reset)
    shut_r |=> seg_on == 8'h00)
    else $error("segments lit during shutdown");
  raw_map_a: assert property (@(posedge ref_clk) disable iff (reset)
    !shut_r |=> seg_on[7] == !$past(raw[RAW_DP_BIT])
             && seg_on[0] == $past(raw[RAW_A_BIT]))
    else $error("raw segment mapping wrong");
  raw_mid_a: assert property (@(posedge ref_clk) disable iff (reset)
    !shut_r |=> seg_on[6:1] == {$past(raw[RAW_G_BIT]), $past(raw[RAW_F_BIT]),
                                $past(raw[RAW_E_BIT]), $past(raw[RAW_D_BIT]),
                                $past(raw[RAW_C_BIT]), $past(raw[RAW_B_BIT])})
    else $error("raw segment mapping wrong in the middle bits");

  // main scenarios reached
  fill_all_c: cover property (@(posedge ref_clk) disable iff (reset)
    loading ##1 state_r == LOAD_FULL);
  shut_store_c: cover property (@(posedge ref_clk) disable iff (reset)
    store && shut_r);
  ignore_c: cover property (@(posedge ref_clk) disable iff (reset)
    state_r == LOAD_FULL && data_wr);
  rewind_c: cover property (@(posedge ref_clk) disable iff (reset)
    loading && cfg_wr && follow);
  cfg_stop_c: cover property (@(posedge ref_clk) disable iff (reset)
    loading && cfg_wr && !follow);
endmodule // seq_display_load

// ---- tb/host_model.sv ----
// host microcontroller model driving mode line, shared bus and write strobe
`timescale 1ns/1ps
module host_model
  import load_port_pkg::*;
(
  input  wire logic             ref_clk,  // system clock
  output logic                  wr_n,     // write strobe, low active
  output logic                  mode_sel, // high = config word
  output logic      [BUS_W-1:0] bus       // host_bus_bits
);
  // idle host: strobe high, bus parked
  initial begin
    wr_n = 1'b1;
    mode_sel = 1'b0;
    bus = 8'h00;
  end

  // one strobe pulse per transfer, two cycles low then two high
  task automatic xfer(input logic m, input logic [BUS_W-1:0] d);
    @(posedge ref_clk);
    mode_sel <= m;
    bus <= d;
    wr_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    wr_n <= 1'b1;
    @(posedge ref_clk);
    bus <= ~d; // bus handed to other parts, so never show a stale byte
    @(posedge ref_clk);
  endtask
endmodule // host_model

// ---- tb/tb_sequential_display_load_port.sv ----
// self-checking bench for the sequential display load port
`timescale 1ns/1ps
module tb_sequential_display_load_port;
  import load_port_pkg::*;
  logic             ref_clk;
  logic             reset;
  logic [PTR_W-1:0] view_digit;
  wire logic             wr_n;
  wire logic             mode_sel;
  wire logic [BUS_W-1:0] bus;
  wire logic [7:0]       seg_on;
  wire logic             shutdown, decode_en, charset_select, loading;
  wire logic [PTR_W-1:0] load_ptr;
  int err_count, samples_checked, cycles;

  host_model i_host_model (.ref_clk(ref_clk), .wr_n(wr_n), .mode_sel(mode_sel), .bus(bus));
  seq_display_load i_seq_display_load (.ref_clk(ref_clk), .reset(reset), .wr_n(wr_n),
    .mode_sel(mode_sel), .input_bus_bits(bus), .view_digit(view_digit), .seg_on(seg_on),
    .shutdown(shutdown), .decode_en(decode_en), .charset_select(charset_select),
    .loading(loading), .load_ptr(load_ptr));

  // clock at 200 MHz
  always #2.5 ref_clk = ~ref_clk;

  // hang guard, far above the some 140 cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // status packed as {shutdown, decode, charset, loading, 0, ptr}
  task automatic status(logic [7:0] e);
    #1; // sample settled values, away from the edge
    chk("status", e, {shutdown, decode_en, charset_select, loading, 1'b0, load_ptr});
  endtask

  // raw byte to lit segments {dp,g,f,e,d,c,b,a}; dp lit on zero
  function automatic logic [7:0] raw_view(logic [7:0] b);
    return {~b[7], b[2], b[1], b[3], b[0], b[4], b[5], b[6]};
  endfunction

  function automatic logic [7:0] pat(int i);
    return 8'h3c ^ (8'h01 << i);
  endfunction

  task automatic view(logic [PTR_W-1:0] d, logic [7:0] e);
    @(posedge ref_clk);
    view_digit <= d;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("seg_on", e, seg_on);
  endtask

  task automatic t_reset_and_refuse();
    status(8'ha0);
    chk("seg_on", 8'h00, seg_on);
    i_host_model.xfer(1'b0, 8'hff);
    status(8'ha0);
  endtask

  // raw, data-follows, shutdown kept: loading must still work
  task automatic t_fill_in_shutdown();
    i_host_model.xfer(1'b1, 8'h80);
    status(8'h90);
    for (int i = 0; i < 8; i++) begin
      i_host_model.xfer(1'b0, pat(i));
      status(i < 7 ? 8'h90 | 8'(i + 1) : 8'h80);
    end
    chk("seg_on", 8'h00, seg_on);
    i_host_model.xfer(1'b0, 8'h00);
    status(8'h80);
  endtask

  task automatic t_raw_view();
    i_host_model.xfer(1'b1, 8'h10);
    status(8'h00);
    for (int d = 0; d < 8; d++) view(3'(d), raw_view(pat(d)));
  endtask

  // rewind in mid-load, then only digit 0 changes
  task automatic t_rewind();
    i_host_model.xfer(1'b1, 8'h90);
    i_host_model.xfer(1'b0, 8'h5a);
    i_host_model.xfer(1'b0, 8'h5a);
    status(8'h12);
    i_host_model.xfer(1'b1, 8'hf0);
    status(8'h70);
    i_host_model.xfer(1'b0, 8'ha5);
    i_host_model.xfer(1'b1, 8'h10);
    view(3'h0, raw_view(8'ha5));
    view(3'h2, raw_view(pat(2)));
  endtask

  task automatic summarize();
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // reset for five cycles, then the scenarios
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    view_digit = 3'h0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset_and_refuse();
    t_fill_in_shutdown();
    t_raw_view();
    t_rewind();
    summarize();
  end
endmodule // tb_sequential_display_load_port
